// ---- lsrd_defines.svh ----
// Behaviour
// - Shift right, zero fill, write destination
// - Register amount uses low eight bits only
// - Flag forms update flags, others do not
// - Immediate field zero means shift thirty-two
// - Short immediate fields at 10:6, 5:3, 2:0
// - Short form inside conditional block: no flags
// - Short form outside conditional block: set flags
// - Wide amount is upper 14:12 with lower
// - Short register form: one field, source and destination
// - Wide forms need main extension enabled
// - Immediate forms act as move with right shift
`ifndef LSRD_DEFINES_SVH
`define LSRD_DEFINES_SVH

// Opcode patterns
`define LSRD_IMM16_OP 5'h01
`define LSRD_REG16_OP 10'h103
`define LSRD_IMM32_OP 11'h752
`define LSRD_IMM32_LOW 4'hf
`define LSRD_REG32_OP 9'h1f4
`define LSRD_REG32_FIX 4'hf
`define LSRD_SHIFT_TYPE_RIGHT 2'h1

// Field positions
`define LSRD_FLAG_SEL_BIT 4
`define LSRD_SHORT_AMT_HI 10
`define LSRD_SHORT_AMT_LO 6
`define LSRD_WIDE_UPPER_HI 14
`define LSRD_WIDE_UPPER_LO 12
`define LSRD_WIDE_LOWER_HI 7
`define LSRD_WIDE_LOWER_LO 6

// Amount that a zero immediate field stands for
`define LSRD_IMM_ZERO_AMOUNT 6'h20

// Register offsets and reset values
`define LSRD_CTRL_OFFSET 8'h00
`define LSRD_EXEC_COUNT_OFFSET 8'h04
`define LSRD_UNDEF_COUNT_OFFSET 8'h08
`define LSRD_CTRL_MAIN_EXT_BIT 0
`define LSRD_CTRL_RESET 1'h1

`endif

// ---- lsrd_pkg.sv ----
package lsrd_pkg;

	typedef enum logic [2:0] {
		LSRD_FORM_NONE = 3'h0,
		LSRD_FORM_IMM16 = 3'h1,
		LSRD_FORM_REG16 = 3'h3,
		LSRD_FORM_IMM32 = 3'h2,
		LSRD_FORM_REG32 = 3'h6
	} lsrd_form_type;

endpackage : lsrd_pkg

// ---- lsrd_core.sv ----
`timescale 1ns/10ps
`include "lsrd_defines.svh"

module lsrd_core (
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Fetch side
	input wire logic instr_valid_i,
	input wire logic instr_wide_i,
	input wire logic [31:0] instr_i,
	input wire logic inside_conditional_block_i,
	// Register file read, data one cycle after address
	output logic [3:0] rf_rd_addr_a_o,
	output logic [3:0] rf_rd_addr_b_o,
	input wire logic [31:0] rf_rd_data_a_i,
	input wire logic [31:0] rf_rd_data_b_i,
	// Register file write
	output logic rf_wr_en_o,
	output logic [3:0] rf_wr_addr_o,
	output logic [31:0] rf_wr_data_o,
	// Condition flags
	input wire logic flag_c_i,
	output logic flags_we_o,
	output logic flag_n_o,
	output logic flag_z_o,
	output logic flag_c_o,
	output logic undef_o,
	// Software port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o
);

	logic [15:0] hw1;
	logic [15:0] hw2;
	lsrd_pkg::lsrd_form_type next_form;
	logic [3:0] next_dest;
	logic [3:0] next_src;
	logic [3:0] next_amt_reg;
	logic [5:0] next_imm;
	logic next_flags;

	logic main_ext_enable;
	logic [31:0] exec_count;
	logic [31:0] undef_count;

	logic s1_valid;
	lsrd_pkg::lsrd_form_type s1_form;
	logic [3:0] s1_dest;
	logic [5:0] s1_imm;
	logic s1_flags;
	logic s1_undef;

	logic s2_valid;
	logic s2_is_reg;
	logic [3:0] s2_dest;
	logic [5:0] s2_imm;
	logic s2_flags;
	logic s2_undef;

	logic [7:0] next_amount;
	logic [31:0] next_result;
	logic next_carry;

	function automatic logic [5:0] decode_amount(input logic [4:0] field);
		if (field == 5'h00) begin
			decode_amount = `LSRD_IMM_ZERO_AMOUNT;
		end else begin
			decode_amount = {1'b0, field};
		end
	endfunction : decode_amount

	function automatic logic [32:0] shift_right(input logic [31:0] value, input logic [7:0] amt);
		logic [32:0] ext;
		ext = {value, 1'b0};
		shift_right = ext >> amt;
	endfunction : shift_right

	assign hw1 = instr_i[15:0];
	assign hw2 = instr_i[31:16];

	always_comb begin
		next_form = lsrd_pkg::LSRD_FORM_NONE;
		next_dest = 4'h0;
		next_src = 4'h0;
		next_amt_reg = 4'h0;
		next_imm = 6'h00;
		next_flags = 1'b0;
		if (!instr_wide_i) begin
			if (hw1[15:11] == `LSRD_IMM16_OP) begin
				next_form = lsrd_pkg::LSRD_FORM_IMM16;
				next_imm = decode_amount(hw1[`LSRD_SHORT_AMT_HI:`LSRD_SHORT_AMT_LO]);
				next_src = {1'b0, hw1[5:3]};
				next_dest = {1'b0, hw1[2:0]};
				next_flags = !inside_conditional_block_i;
			end else if (hw1[15:6] == `LSRD_REG16_OP) begin
				next_form = lsrd_pkg::LSRD_FORM_REG16;
				// one field for source and destination
				next_src = {1'b0, hw1[2:0]};
				next_dest = {1'b0, hw1[2:0]};
				next_amt_reg = {1'b0, hw1[5:3]};
				next_flags = !inside_conditional_block_i;
			end
		end else begin
			if (hw1[15:5] == `LSRD_IMM32_OP && hw1[3:0] == `LSRD_IMM32_LOW &&
				!hw2[15] && hw2[5:4] == `LSRD_SHIFT_TYPE_RIGHT) begin
				next_form = lsrd_pkg::LSRD_FORM_IMM32;
				next_imm = decode_amount({hw2[`LSRD_WIDE_UPPER_HI:`LSRD_WIDE_UPPER_LO],
					hw2[`LSRD_WIDE_LOWER_HI:`LSRD_WIDE_LOWER_LO]});
				next_dest = hw2[11:8];
				next_src = hw2[3:0];
				next_flags = hw1[`LSRD_FLAG_SEL_BIT];
			end else if (hw1[15:7] == `LSRD_REG32_OP &&
				hw1[6:5] == `LSRD_SHIFT_TYPE_RIGHT &&
				hw2[15:12] == `LSRD_REG32_FIX && hw2[7:4] == 4'h0) begin
				next_form = lsrd_pkg::LSRD_FORM_REG32;
				next_src = hw1[3:0];
				next_dest = hw2[11:8];
				next_amt_reg = hw2[3:0];
				next_flags = hw1[`LSRD_FLAG_SEL_BIT];
			end
		end
	end

	// Decode stage
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_valid <= 1'b0;
			s1_form <= lsrd_pkg::LSRD_FORM_NONE;
			s1_dest <= 4'h0;
			s1_imm <= 6'h00;
			s1_flags <= 1'b0;
			s1_undef <= 1'b0;
			rf_rd_addr_a_o <= 4'h0;
			rf_rd_addr_b_o <= 4'h0;
		end else begin
			s1_valid <= instr_valid_i && next_form != lsrd_pkg::LSRD_FORM_NONE;
			s1_form <= next_form;
			s1_dest <= next_dest;
			s1_imm <= next_imm;
			s1_flags <= next_flags;
			s1_undef <= (next_form == lsrd_pkg::LSRD_FORM_IMM32 ||
				next_form == lsrd_pkg::LSRD_FORM_REG32) && !main_ext_enable;
			rf_rd_addr_a_o <= next_src;
			rf_rd_addr_b_o <= next_amt_reg;
		end
	end

	// Operand stage, waits for register file data
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s2_valid <= 1'b0;
			s2_is_reg <= 1'b0;
			s2_dest <= 4'h0;
			s2_imm <= 6'h00;
			s2_flags <= 1'b0;
			s2_undef <= 1'b0;
		end else begin
			s2_valid <= s1_valid;
			s2_is_reg <= s1_form == lsrd_pkg::LSRD_FORM_REG16 ||
				s1_form == lsrd_pkg::LSRD_FORM_REG32;
			s2_dest <= s1_dest;
			s2_imm <= s1_imm;
			s2_flags <= s1_flags;
			s2_undef <= s1_undef;
		end
	end

	always_comb begin
		// immediate forms share the move shifter
		next_amount = s2_is_reg ? rf_rd_data_b_i[7:0] : {2'h0, s2_imm};
		{next_result, next_carry} = shift_right(rf_rd_data_a_i, next_amount);
		if (next_amount == 8'h00) begin
			next_carry = flag_c_i;
		end
	end

	// Result write
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rf_wr_en_o <= 1'b0;
			rf_wr_addr_o <= 4'h0;
			rf_wr_data_o <= 32'h0000_0000;
			undef_o <= 1'b0;
		end else begin
			rf_wr_en_o <= s2_valid && !s2_undef;
			rf_wr_addr_o <= s2_dest;
			rf_wr_data_o <= next_result;
			undef_o <= s2_valid && s2_undef;
		end
	end

	// Flag update
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flags_we_o <= 1'b0;
			flag_n_o <= 1'b0;
			flag_z_o <= 1'b0;
			flag_c_o <= 1'b0;
		end else begin
			flags_we_o <= s2_valid && !s2_undef && s2_flags;
			flag_n_o <= next_result[31];
			flag_z_o <= next_result == 32'h0000_0000;
			// carry is last bit shifted out
			flag_c_o <= next_carry;
		end
	end

	// Control register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_ext_enable <= `LSRD_CTRL_RESET;
		end else if (reg_we_i && reg_addr_i == `LSRD_CTRL_OFFSET) begin
			main_ext_enable <= reg_wdata_i[`LSRD_CTRL_MAIN_EXT_BIT];
		end
	end

	// Event counters, write of any value clears, an event counted in the same cycle wins
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			exec_count <= 32'h0000_0000;
		end else if (s2_valid && !s2_undef) begin
			exec_count <= exec_count + 32'h0000_0001;
		end else if (reg_we_i && reg_addr_i == `LSRD_EXEC_COUNT_OFFSET) begin
			exec_count <= 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			undef_count <= 32'h0000_0000;
		end else if (s2_valid && s2_undef) begin
			undef_count <= undef_count + 32'h0000_0001;
		end else if (reg_we_i && reg_addr_i == `LSRD_UNDEF_COUNT_OFFSET) begin
			undef_count <= 32'h0000_0000;
		end
	end

	// Read data, zero outside reads and for unmapped offsets
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				`LSRD_CTRL_OFFSET: begin
					reg_rdata_o <= {31'h0000_0000, main_ext_enable};
				end
				`LSRD_EXEC_COUNT_OFFSET: begin
					reg_rdata_o <= exec_count;
				end
				`LSRD_UNDEF_COUNT_OFFSET: begin
					reg_rdata_o <= undef_count;
				end
				default: begin
					reg_rdata_o <= 32'h0000_0000;
				end
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

endmodule : lsrd_core

// ---- lsrd_sva.sv ----
`timescale 1ns/10ps
module lsrd_sva (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic instr_wide_i,
	input wire logic [31:0] instr_i,
	input wire logic inside_conditional_block_i,
	input wire logic [3:0] rf_rd_addr_a_o,
	input wire logic [3:0] rf_rd_addr_b_o,
	input wire logic rf_wr_en_o,
	input wire logic [3:0] rf_wr_addr_o,
	input wire logic [31:0] rf_wr_data_o,
	input wire logic flags_we_o,
	input wire logic flag_n_o,
	input wire logic flag_z_o,
	input wire logic undef_o
);
	logic s_imm;
	logic s_reg;
	assign s_imm = instr_valid_i && !instr_wide_i && instr_i[15:11] == 5'h01;
	assign s_reg = instr_valid_i && !instr_wide_i && instr_i[15:6] == 10'h103;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	chk_short_dest: assert property (s_imm |-> ##3 rf_wr_en_o
		&& rf_wr_addr_o == {1'b0, $past(instr_i[2:0], 3)}) else $error("short dest wrong");
	chk_short_src: assert property (s_imm |-> ##1
		rf_rd_addr_a_o == {1'b0, $past(instr_i[5:3])}) else $error("short source wrong");
	chk_zero_field: assert property (s_imm && instr_i[10:6] == 5'h00
		|-> ##3 rf_wr_data_o == 32'h0) else $error("zero field not 32");
	chk_flags_inside: assert property ((s_imm || s_reg) && inside_conditional_block_i
		|-> ##3 !flags_we_o) else $error("flags set inside block");
	chk_flags_outside: assert property (s_imm && !inside_conditional_block_i
		|-> ##3 flags_we_o) else $error("flags not set outside block");
	chk_reg_pair: assert property (s_reg |-> ##1
		rf_rd_addr_a_o == {1'b0, $past(instr_i[2:0])}
		##2 rf_wr_addr_o == {1'b0, $past(instr_i[2:0], 3)}) else $error("pair wrong");
	chk_amount_port: assert property (s_reg |-> ##1
		rf_rd_addr_b_o == {1'b0, $past(instr_i[5:3])}) else $error("amount reg wrong");
	chk_flag_values: assert property (flags_we_o |-> flag_z_o == (rf_wr_data_o == 32'h0)
		&& flag_n_o == rf_wr_data_o[31]) else $error("n or z wrong");
	chk_undef_quiet: assert property (undef_o |-> !rf_wr_en_o && !flags_we_o)
		else $error("undef with write");
endmodule : lsrd_sva

bind lsrd_core lsrd_sva chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.instr_valid_i(instr_valid_i), .instr_wide_i(instr_wide_i), .instr_i(instr_i),
	.inside_conditional_block_i(inside_conditional_block_i),
	.rf_rd_addr_a_o(rf_rd_addr_a_o), .rf_rd_addr_b_o(rf_rd_addr_b_o),
	.rf_wr_en_o(rf_wr_en_o), .rf_wr_addr_o(rf_wr_addr_o), .rf_wr_data_o(rf_wr_data_o),
	.flags_we_o(flags_we_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .undef_o(undef_o));

// ---- lsrd_rf_model.sv ----
`timescale 1ns/10ps
module lsrd_rf_model (
	input wire logic core_clk_i,
	input wire logic [3:0] rd_addr_a_i,
	input wire logic [3:0] rd_addr_b_i,
	output logic [31:0] rd_data_a_o,
	output logic [31:0] rd_data_b_o
);
	logic [31:0] mem [16];
	initial begin
		rd_data_a_o = 32'h0;
		rd_data_b_o = 32'h0;
	end
	// Data one cycle after address
	always @(posedge core_clk_i) begin
		rd_data_a_o <= mem[rd_addr_a_i];
		rd_data_b_o <= mem[rd_addr_b_i];
	end
endmodule : lsrd_rf_model

// ---- logical_shift_right_decode_tb.sv ----
`timescale 1ns/10ps
module logical_shift_right_decode_tb;
	logic clk = 0;
	logic rst = 1;
	logic iv = 0;
	logic iw = 0;
	logic blk = 0;
	logic fc = 0;
	logic we = 0;
	logic re = 0;
	logic ext = 1;
	logic [31:0] ins = 0;
	logic [31:0] wd = 0;
	logic [7:0] ra = 0;
	logic [31:0] da, db, wdat, rdat;
	logic [3:0] aa, ab, waddr;
	logic wen, fwe, fn, fz, fco, und;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int nexec = 0;
	int nund = 0;
	always #2.5 clk = ~clk;
	lsrd_core uut (.core_clk_i(clk), .rst_i(rst), .instr_valid_i(iv), .instr_wide_i(iw),
		.instr_i(ins), .inside_conditional_block_i(blk), .rf_rd_addr_a_o(aa),
		.rf_rd_addr_b_o(ab), .rf_rd_data_a_i(da), .rf_rd_data_b_i(db), .rf_wr_en_o(wen),
		.rf_wr_addr_o(waddr), .rf_wr_data_o(wdat), .flag_c_i(fc), .flags_we_o(fwe),
		.flag_n_o(fn), .flag_z_o(fz), .flag_c_o(fco), .undef_o(und), .reg_addr_i(ra),
		.reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat));
	lsrd_rf_model rf (.core_clk_i(clk), .rd_addr_a_i(aa), .rd_addr_b_i(ab),
		.rd_data_a_o(da), .rd_data_b_o(db));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		we <= w;
		re <= !w;
		ra <= a;
		wd <= e;
		@(posedge clk);
		we <= 0;
		re <= 0;
		#1;
		if (!w)
			chk("reg_rdata", e, rdat);
	endtask : rg
	task automatic op(input int k, input logic s, input logic b, input logic [4:0] sh,
		input logic [7:0] a8);
		logic [3:0] m, d, r;
		logic [31:0] v, e;
		logic ci, c, fl, u;
		int amt;
		m = (k > 1) ? 4'($urandom) : {1'b0, 3'($urandom)};
		d = (k == 1) ? m : (k > 1) ? 4'($urandom) : {1'b0, 3'($urandom)};
		r = m ^ 4'h1;
		v = $urandom;
		ci = 1'($urandom);
		rf.mem[m] = v;
		rf.mem[r] = {24'($urandom), a8};
		amt = k[0] ? int'(a8) : (sh == 0 ? 32 : int'(sh));
		c = (amt == 0) ? ci : (amt > 32) ? 1'b0 : v[amt - 1];
		fl = (k < 2) ? !b : s;
		u = k > 1 && !ext;
		case (k)
			0: e = {16'h0, 5'h01, sh, m[2:0], d[2:0]};
			1: e = {16'h0, 10'h103, r[2:0], m[2:0]};
			2: e = {1'b0, sh[4:2], d, sh[1:0], 2'b01, m, 11'h752, s, 4'hf};
			default: e = {4'hf, d, 4'h0, r, 9'h1f4, 2'b01, s, m};
		endcase
		@(posedge clk);
		iv <= 1;
		iw <= k > 1;
		ins <= e;
		blk <= b;
		fc <= ci;
		@(posedge clk);
		iv <= 0;
		repeat (2) @(posedge clk);
		#1;
		chk("undef", u, und);
		chk("wr_en", !u, wen);
		chk("flags_we", fl && !u, fwe);
		if (u)
			nund++;
		else begin
			nexec++;
			chk("wr_addr", d, waddr);
			chk("wr_data", v >> amt, wdat);
			if (fl) begin
				chk("carry", c, fco);
				chk("flag_n", (v >> amt) >> 31, fn);
				chk("flag_z", (v >> amt) == 32'h0, fz);
			end
		end
	endtask : op
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		byte unsigned am[6] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hff};
		void'($urandom(32'h12f6));
		repeat (2) @(posedge clk);
		rst <= 0;
		rg(0, 8'h00, 32'h1);
		op(0, 0, 0, 5'h00, 8'h0);
		op(2, 1, 1, 5'h00, 8'h0);
		foreach (am[i]) begin
			op(1, 0, i % 2, 5'h0, am[i]);
			op(3, i % 2, 0, 5'h0, am[i]);
		end
		for (int i = 0; i < 300; i++)
			op($urandom % 4, 1'($urandom), 1'($urandom), 5'($urandom), 8'($urandom));
		rg(0, 8'h04, nexec);
		rg(1, 8'h00, 32'h0);
		ext = 0;
		op(2, 1, 0, 5'h05, 8'h0);
		op(3, 0, 0, 5'h0, 8'h03);
		op(0, 0, 0, 5'h07, 8'h0);
		rg(0, 8'h08, nund);
		rg(0, 8'h0c, 32'h0);
		rg(1, 8'h04, 32'h0);
		rg(0, 8'h04, 32'h0);
		tally_and_finish();
	end
endmodule : logical_shift_right_decode_tb
